//--- src/fifo_level_tracker.sv
// Occupancy tracker for a rate-matching FIFO: counts pushes and pops,
// starts draining at a start level and flags overflow and underflow.
// Assumes push and pop are one-cycle pulses on the same clock.
`timescale 1ns/1ps
module fifo_level_tracker
  import mac_cfg_pkg::*;
(
  input wire logic clk,             // Core clock
  input wire logic arst_n,          // Asynchronous reset, active low
  input wire logic enable,          // Tracker in use
  input wire logic frame,           // Frame in progress
  input wire logic push,            // Write one entry
  input wire logic pop_req,         // Read slot
  input wire logic [4:0] limit,     // Capacity
  input wire logic [4:0] start,     // Level that starts draining
  output logic [4:0] level,         // Current occupancy
  output logic overflow,            // Push refused, one cycle
  output logic underflow            // Pop with nothing stored, one cycle
);

  logic draining;
  wire do_pop = pop_req && draining && (level != 5'h00);
  wire do_push = push && ((level < limit) || do_pop);
  wire next_over = enable && push && !do_push;
  wire next_under = enable && pop_req && draining && frame && (level == 5'h00);

  ////////////////////////////////////////////////////////////////////////
  // Level counter; a disabled tracker forgets its contents
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      level <= 5'h00;
    end else if (!enable) begin
      level <= 5'h00;
    end else if (do_push && !do_pop) begin
      level <= level + 5'h01;
    end else if (do_pop && !do_push) begin
      level <= level - 5'h01;
    end
  end

  // Drain starts at the start level, ends once empty after the frame
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      draining <= 1'b0;
    end else if (!enable) begin
      draining <= 1'b0;
    end else if (level >= start) begin
      draining <= 1'b1;
    end else if (!frame && level == 5'h00) begin
      draining <= 1'b0;
    end
  end

  // Error pulses
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      overflow <= 1'b0;
      underflow <= 1'b0;
    end else begin
      overflow <= next_over;
      underflow <= next_under;
    end
  end

endmodule

//--- src/mac_cfg_pkg.sv
// Package of the MAC-side interface configuration block: register
// indexes, field positions, reset values, timing counts and state codes.
// Assumes a 100 MHz core clock and an APB slave with 32-bit data.
package mac_cfg_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned RMII_FAST_HZ = 50_000_000;
  localparam int unsigned RMII_SLOW_HZ = 5_000_000;
  localparam logic [4:0] FAST_DIV = 5'(CLK_HZ / RMII_FAST_HZ);
  localparam logic [4:0] SLOW_DIV = 5'(CLK_HZ / RMII_SLOW_HZ);

  ////////////////////////////////////////////////////////////////////////
  // Register indexes; byte address is four times the index
  localparam int ADDR_W = 10;
  localparam logic [7:0] IDX_CFG_ONE = 8'h17;
  localparam logic [7:0] IDX_CFG_TWO = 8'h18;
  localparam logic [7:0] IDX_STRAP = 8'h19;
  localparam logic [7:0] IDX_INT_STATUS = 8'h1a;
  localparam logic [7:0] IDX_INT_MASK = 8'h1b;

  ////////////////////////////////////////////////////////////////////////
  // Reset values and writable masks
  localparam logic [15:0] CFG_ONE_RST = 16'h4001;
  localparam logic [15:0] CFG_TWO_RST = 16'h0003;
  localparam logic [15:0] STRAP_RST = 16'h0000;
  localparam logic [15:0] CFG_ONE_WMASK = 16'hfbf3;
  localparam logic [15:0] CFG_TWO_WMASK = 16'h0c3f;

  ////////////////////////////////////////////////////////////////////////
  // Field positions, first configuration register
  localparam int B_RX_SHIFT = 12;
  localparam int B_TX_SHIFT = 11;
  localparam int B_RGMII_EN = 9;
  localparam int B_REF_50 = 7;
  localparam int B_SLOW = 6;
  localparam int B_RMII_MODE = 5;
  localparam int B_LEGACY_REV = 4;
  localparam int B_OVF = 3;
  localparam int B_UNF = 2;
  localparam int B_ELAST_HI = 1;
  // Field positions, second configuration register and strap register
  localparam int B_CV_SEL = 10;
  localparam int B_AEMPTY = 9;
  localparam int B_AFULL = 8;
  localparam int B_TXER_SUP = 3;
  localparam int B_THR_HI = 2;
  localparam int B_STRAP_HI = 4;

  ////////////////////////////////////////////////////////////////////////
  // Elastic tolerance settings and transmit FIFO depth
  localparam logic [4:0] TOL_SEL0 = 5'd14;
  localparam logic [4:0] TOL_SEL1 = 5'd2;
  localparam logic [4:0] TOL_SEL2 = 5'd6;
  localparam logic [4:0] TOL_SEL3 = 5'd10;
  localparam logic [4:0] TX_FIFO_DEPTH = 5'd8;

  ////////////////////////////////////////////////////////////////////////
  // Interrupt event bits and synchroniser width
  localparam int NUM_EV = 4;
  localparam int EV_OVF = 0;
  localparam int EV_UNF = 1;
  localparam int EV_AEMPTY = 2;
  localparam int EV_AFULL = 3;
  localparam int SYNC_W = 4;

  typedef enum logic [1:0] {
    DV_IDLE = 2'b00,
    DV_CARRIER = 2'b01,
    DV_DRAIN = 2'b10
  } dv_state_t;

endpackage

//--- src/mac_interface_config_regs.sv
// MAC-side interface configuration and status registers behind APB,
// with the carrier/data-valid generator, RMII clock divider, transmit
// error filter and the two FIFO trackers that raise the error flags.
// Assumes LINK_CLK and MAC transmit pins come from outside the clock
// domain; core carrier and data valid come from logic on REF_CLK.
`timescale 1ns/1ps
module mac_interface_config_regs
  import mac_cfg_pkg::*;
(
  input wire logic REF_CLK,                // Core clock, 100 MHz
  input wire logic ARST_N,                 // Asynchronous reset, active low
  input wire logic PSEL,                   // APB select
  input wire logic PENABLE,                // APB access phase
  input wire logic PWRITE,                 // APB write
  input wire logic [ADDR_W-1:0] PADDR,     // APB byte address
  input wire logic [31:0] PWDATA,          // APB write data
  output logic [31:0] PRDATA,              // APB read data
  output logic PREADY,                     // APB ready, no wait states
  output logic PSLVERR,                    // APB error on unmapped address
  input wire logic LINK_CLK,               // MAC-side link clock
  input wire logic MAC_TX_EN,              // MAC transmit enable
  input wire logic MAC_TX_ER,              // MAC transmit error
  input wire logic FULL_DUPLEX,            // Link is full duplex
  input wire logic CORE_CRS,               // Carrier sense from receiver
  input wire logic CORE_RX_DV,             // Receive data valid from receiver
  input wire logic [4:0] STRAP_PHY_ADDR,   // Address strap pins
  output logic RGMII_EN,                   // RGMII selected
  output logic RGMII_RX_CLK_SHIFT,         // Receive clock delayed
  output logic RGMII_TX_CLK_SHIFT,         // Transmit clock taken as delayed
  output logic RMII_SEL,                   // RMII in use
  output logic MII_SEL,                    // MII in use
  output logic REF_CLK_50_SEL,             // Reference input is 50 MHz
  output logic RMII_CLK_OUT,               // RMII master reference clock
  output logic CRS_DV_OUT,                 // Combined carrier/data valid
  output logic TX_ER_OUT,                  // Filtered transmit error
  output logic IRQ                         // Interrupt, active high level
);

  ////////////////////////////////////////////////////////////////////////
  // Decoding helpers
  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [7:0] idx);
    reg_hit = (addr == {idx, 2'b00});
  endfunction

  function automatic logic [4:0] tolerance(input logic [1:0] sel);
    case (sel)
      2'b00: tolerance = TOL_SEL0;
      2'b01: tolerance = TOL_SEL1;
      2'b10: tolerance = TOL_SEL2;
      default: tolerance = TOL_SEL3;
    endcase
  endfunction

  logic [15:0] cfg_one;
  logic [15:0] cfg_two;
  logic [4:0] strapped_address;
  logic [NUM_EV-1:0] int_status;
  logic [NUM_EV-1:0] int_mask;
  logic tx_fifo_almost_empty_error;
  logic tx_fifo_almost_full_error;
  dv_state_t state;
  dv_state_t next_state;
  logic dv_toggle;
  logic [4:0] div_cnt;
  logic [1:0] strap_wait;
  logic rmii_ovf;
  logic rmii_unf;
  logic tx_aempty;
  logic tx_afull;
  logic link_prev;
  logic [SYNC_W-1:0] sync_a;
  logic [SYNC_W-1:0] sync_b;

  ////////////////////////////////////////////////////////////////////////
  // Two-flop synchronisers for pins from the MAC side
  wire [SYNC_W-1:0] pins_in = {FULL_DUPLEX, MAC_TX_ER, MAC_TX_EN, LINK_CLK};
  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
      always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
          sync_a[gi] <= 1'b0;
          sync_b[gi] <= 1'b0;
        end else begin
          sync_a[gi] <= pins_in[gi];
          sync_b[gi] <= sync_a[gi];
        end
      end
    end
  endgenerate

  wire link_s = sync_b[0];
  wire tx_en_s = sync_b[1];
  wire tx_er_s = sync_b[2];
  wire fd_s = sync_b[3];
  wire link_tick = link_s && !link_prev;

  ////////////////////////////////////////////////////////////////////////
  // APB decode
  wire hit_one = reg_hit(PADDR, IDX_CFG_ONE);
  wire hit_two = reg_hit(PADDR, IDX_CFG_TWO);
  wire hit_strap = reg_hit(PADDR, IDX_STRAP);
  wire hit_stat = reg_hit(PADDR, IDX_INT_STATUS);
  wire hit_mask = reg_hit(PADDR, IDX_INT_MASK);
  wire hit_any = hit_one || hit_two || hit_strap || hit_stat || hit_mask;
  wire access = PSEL && PENABLE;
  wire wr_en = access && PWRITE;
  wire wr_one = wr_en && hit_one;
  wire wr_two = wr_en && hit_two;
  wire [NUM_EV-1:0] w1c = (wr_en && hit_stat) ? PWDATA[NUM_EV-1:0] : '0;
  assign PREADY = 1'b1;
  assign PSLVERR = access && !hit_any;

  // Readback views; reserved bits read zero
  wire [15:0] view_one = cfg_one;
  wire [15:0] view_two = {cfg_two[15:10], tx_fifo_almost_empty_error,
                          tx_fifo_almost_full_error, cfg_two[7:0]};
  wire [31:0] rd_mux = hit_one ? {16'h0000, view_one} :
                       hit_two ? {16'h0000, view_two} :
                       hit_strap ? {27'h0000000, strapped_address} :
                       hit_stat ? {28'h0000000, int_status} :
                       hit_mask ? {28'h0000000, int_mask} : 32'h00000000;

  // Read data latched in the setup phase so it comes from a flop
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      PRDATA <= 32'h00000000;
    end else if (PSEL && !PENABLE && !PWRITE) begin
      PRDATA <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Configuration registers; sticky flags clear on a zero write unless an event sets them in the same cycle
  wire clr_ovf = wr_one && !PWDATA[B_OVF];
  wire clr_unf = wr_one && !PWDATA[B_UNF];
  wire next_ovf = rmii_ovf || (cfg_one[B_OVF] && !clr_ovf);
  wire next_unf = rmii_unf || (cfg_one[B_UNF] && !clr_unf);
  wire [15:0] one_keep = cfg_one & CFG_ONE_WMASK;
  wire [15:0] one_new = wr_one ? (PWDATA[15:0] & CFG_ONE_WMASK) : one_keep;
  wire [15:0] two_new = wr_two ? (PWDATA[15:0] & CFG_TWO_WMASK) : (cfg_two & CFG_TWO_WMASK);

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cfg_one <= CFG_ONE_RST;
      cfg_two <= CFG_TWO_RST;
    end else begin
      cfg_one <= {one_new[15:4], next_ovf, next_unf, one_new[1:0]};
      cfg_two <= two_new;
    end
  end

  // Transmit FIFO error bits stay until RGMII is turned off
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      tx_fifo_almost_empty_error <= 1'b0;
      tx_fifo_almost_full_error <= 1'b0;
    end else begin
      tx_fifo_almost_empty_error <= tx_aempty || (tx_fifo_almost_empty_error && RGMII_EN);
      tx_fifo_almost_full_error <= tx_afull || (tx_fifo_almost_full_error && RGMII_EN);
    end
  end

  // Strap caught once the synchronised pins have settled after reset
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      strap_wait <= 2'b00;
      strapped_address <= STRAP_RST[B_STRAP_HI:0];
    end else if (strap_wait != 2'b11) begin
      strap_wait <= strap_wait + 2'b01;
      if (strap_wait == 2'b10) begin
        strapped_address <= STRAP_PHY_ADDR;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt status, set wins over the clear
  wire [NUM_EV-1:0] events = {tx_afull, tx_aempty, rmii_unf, rmii_ovf};
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      int_status <= '0;
      int_mask <= '0;
    end else begin
      int_status <= events | (int_status & ~w1c);
      if (wr_en && hit_mask) begin
        int_mask <= PWDATA[NUM_EV-1:0];
      end
    end
  end
  assign IRQ = |(int_status & int_mask);

  ////////////////////////////////////////////////////////////////////////
  // Mode outputs
  assign RGMII_EN = cfg_one[B_RGMII_EN];
  assign RGMII_RX_CLK_SHIFT = cfg_one[B_RX_SHIFT];
  assign RGMII_TX_CLK_SHIFT = cfg_one[B_TX_SHIFT];
  assign RMII_SEL = !RGMII_EN && cfg_one[B_RMII_MODE];
  assign MII_SEL = !RGMII_EN && !cfg_one[B_RMII_MODE];
  assign REF_CLK_50_SEL = cfg_one[B_REF_50];
  wire slow_mode = cfg_one[B_SLOW];
  wire legacy_revision_select = cfg_one[B_LEGACY_REV];
  wire carrier_valid_output_select = cfg_two[B_CV_SEL];
  wire tx_error_suppress = cfg_two[B_TXER_SUP];
  wire [4:0] tx_sync_fifo_threshold = {2'b00, cfg_two[B_THR_HI:0]};
  wire [4:0] rmii_limit = tolerance(cfg_one[B_ELAST_HI:0]);

  ////////////////////////////////////////////////////////////////////////
  // RMII master clock divider; the count runs on across a mode change and wraps at the new divide
  wire [4:0] cur_div = slow_mode ? SLOW_DIV : FAST_DIV;
  wire local_tick = (div_cnt == 5'h00);
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      div_cnt <= 5'h00;
      RMII_CLK_OUT <= 1'b0;
      link_prev <= 1'b0;
    end else begin
      div_cnt <= (div_cnt >= cur_div - 5'h01) ? 5'h00 : div_cnt + 5'h01;
      RMII_CLK_OUT <= (div_cnt < (cur_div >> 1));
      link_prev <= link_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // FIFO trackers: RMII receive elastic buffer and RGMII transmit sync
  fifo_level_tracker u_rmii_elastic (
    .clk(REF_CLK),
    .arst_n(ARST_N),
    .enable(RMII_SEL),
    .frame(CORE_RX_DV),
    .push(local_tick && CORE_RX_DV),
    .pop_req(link_tick),
    .limit(rmii_limit),
    .start({1'b0, rmii_limit[4:1]}),
    .level(),
    .overflow(rmii_ovf),
    .underflow(rmii_unf)
  );

  fifo_level_tracker u_tx_sync (
    .clk(REF_CLK),
    .arst_n(ARST_N),
    .enable(RGMII_EN),
    .frame(tx_en_s),
    .push(link_tick && tx_en_s),
    .pop_req(local_tick),
    .limit(TX_FIFO_DEPTH),
    .start(tx_sync_fifo_threshold),
    .level(),
    .overflow(tx_afull),
    .underflow(tx_aempty)
  );

  ////////////////////////////////////////////////////////////////////////
  // Carrier/data-valid sequencer
  always_comb begin
    next_state = state;
    case (state)
      DV_IDLE: if (CORE_CRS) next_state = DV_CARRIER;
      DV_CARRIER: begin
        if (!CORE_CRS) next_state = CORE_RX_DV ? DV_DRAIN : DV_IDLE;
      end
      DV_DRAIN: begin
        if (CORE_CRS) next_state = DV_CARRIER;
        else if (!CORE_RX_DV) next_state = DV_IDLE;
      end
      default: next_state = DV_IDLE;
    endcase
  end

  // Legacy toggling follows the RMII clock so the MAC sees whole periods
  wire rev10_level = (state == DV_CARRIER) || ((state == DV_DRAIN) && dv_toggle);
  wire rev12_level = (state != DV_IDLE);
  wire dv_level = legacy_revision_select ? rev10_level : rev12_level;
  wire next_crs_dv = !RMII_SEL ? CORE_RX_DV :
                     carrier_valid_output_select ? CORE_CRS : dv_level;
  wire next_tx_er = tx_er_s && !(tx_error_suppress && fd_s && !tx_en_s);

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state <= DV_IDLE;
      dv_toggle <= 1'b0;
      CRS_DV_OUT <= 1'b0;
      TX_ER_OUT <= 1'b0;
    end else begin
      state <= next_state;
      dv_toggle <= (state == DV_DRAIN) ? (dv_toggle ^ local_tick) : 1'b0;
      CRS_DV_OUT <= next_crs_dv;
      TX_ER_OUT <= next_tx_er;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!ARST_N);

  logic [4:0] tick_gap;
  logic slow_held;
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      tick_gap <= 5'h00;
      slow_held <= 1'b0;
    end else begin
      tick_gap <= local_tick ? 5'h00 : tick_gap + 5'h01;
      slow_held <= slow_mode && (slow_held || local_tick);
    end
  end

  a_rx_skew_write: assert property (
    wr_one |=> RGMII_RX_CLK_SHIFT == $past(PWDATA[B_RX_SHIFT]))
    else $error("Receive skew output does not follow write");
  a_tx_skew_write: assert property (
    wr_one |=> RGMII_TX_CLK_SHIFT == $past(PWDATA[B_TX_SHIFT]))
    else $error("Transmit skew output does not follow write");
  a_mode_exclusive: assert property (RGMII_EN |-> !RMII_SEL && !MII_SEL)
    else $error("MII or RMII selected while RGMII enabled");
  a_slow_tick_gap: assert property (
    local_tick && slow_held && slow_mode |-> tick_gap == SLOW_DIV - 5'h01)
    else $error("Slow RMII clock period wrong");
  a_legacy_toggle: assert property (
    RMII_SEL && !carrier_valid_output_select && legacy_revision_select
      && state == DV_DRAIN && next_state == DV_DRAIN |=> CRS_DV_OUT == $past(dv_toggle))
    else $error("Legacy carrier/valid not toggling in drain");
  a_hold_valid: assert property (
    RMII_SEL && !carrier_valid_output_select && !legacy_revision_select
      && state != DV_IDLE |=> CRS_DV_OUT)
    else $error("Carrier/valid dropped before last data");
  a_ovf_set_wins: assert property (rmii_ovf |=> cfg_one[B_OVF] && int_status[EV_OVF])
    else $error("Overflow event lost");
  a_zero_clears: assert property (wr_one && !PWDATA[B_UNF] && !rmii_unf |=> !cfg_one[B_UNF])
    else $error("Underflow flag not cleared by zero write");
  a_tolerance_sel: assert property (
    wr_one && PWDATA[1:0] == 2'b00 |=> rmii_limit == TOL_SEL0)
    else $error("Tolerance selection wrong");
  a_carrier_select: assert property (
    RMII_SEL && carrier_valid_output_select |=> CRS_DV_OUT == $past(CORE_CRS))
    else $error("Carrier sense not on combined pin");
  a_txer_suppress: assert property (tx_error_suppress && fd_s && !tx_en_s |=> !TX_ER_OUT)
    else $error("Transmit error not suppressed");
  a_tx_err_bits: assert property (tx_aempty |=> tx_fifo_almost_empty_error)
    else $error("Almost-empty error not reported");

  c_legacy_drain: cover property (legacy_revision_select && RMII_SEL && state == DV_DRAIN
    ##1 dv_toggle);
  c_overflow: cover property (rmii_ovf);
  c_tx_afull: cover property (tx_afull ##1 IRQ);
  c_slow_mode: cover property (slow_held && local_tick);

endmodule

//--- tb/mac_interface_config_regs_tb_top.sv
// Testbench of the MAC interface configuration registers.
// Assumes an APB slave; reads are checked from a queue by a monitor.
`timescale 1ns/1ps
module mac_interface_config_regs_tb_top;
  import mac_cfg_pkg::*;
  logic ref_clk, arst_n, psel, penable, pwrite, run, crs, dv;
  logic [9:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [4:0] strap;
  logic [15:0] w, w2;
  logic pready, pslverr, link_clk, tx_en, tx_er, fd;
  logic rg, rx_sh, tx_sh, rmii, mii, ref50, rmii_clk, crs_dv, tx_er_out, irq;
  int fail_count, check_count, seed;
  logic [32:0] exp_q[$];
  mac_link_model mac (.run(run), .link_clk(link_clk), .tx_en(tx_en), .tx_er(tx_er), .fd(fd));
  mac_interface_config_regs uut (.REF_CLK(ref_clk), .ARST_N(arst_n), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .LINK_CLK(link_clk), .MAC_TX_EN(tx_en),
    .MAC_TX_ER(tx_er), .FULL_DUPLEX(fd), .CORE_CRS(crs), .CORE_RX_DV(dv),
    .STRAP_PHY_ADDR(strap), .RGMII_EN(rg), .RGMII_RX_CLK_SHIFT(rx_sh),
    .RGMII_TX_CLK_SHIFT(tx_sh), .RMII_SEL(rmii), .MII_SEL(mii), .REF_CLK_50_SEL(ref50),
    .RMII_CLK_OUT(rmii_clk), .CRS_DV_OUT(crs_dv), .TX_ER_OUT(tx_er_out), .IRQ(irq));
  always #5 ref_clk = ~ref_clk;
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input string n, input logic [32:0] e, input logic [32:0] g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Request held until pready is sampled high, released only after it
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [15:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {16'h0000, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] idx, input logic [32:0] e);
    exp_q.push_back(e);
    apb(1'b0, idx, 16'h0000);
  endtask
  task automatic frame(input logic c, input logic d, input logic e);
    @(posedge ref_clk);
    crs <= c;
    dv <= d;
    repeat (4) @(negedge ref_clk);
    check("crs_dv", e, crs_dv);
  endtask
  // Carrier drops while data still drains; count edges on the combined pin
  task automatic drain(input logic [15:0] cfg, input logic e);
    int n;
    logic p;
    n = 0;
    apb(1'b1, IDX_CFG_ONE, cfg);
    frame(1'b1, 1'b1, 1'b1);
    @(posedge ref_clk);
    crs <= 1'b0;
    p = crs_dv;
    repeat (24) begin
      @(negedge ref_clk);
      n += int'(crs_dv !== p);
      p = crs_dv;
    end
    check("toggle", e, n > 0);
    frame(1'b0, 1'b0, 1'b0);
  endtask
  task automatic period(input logic [15:0] cfg, input logic [32:0] e);
    time t;
    apb(1'b1, IDX_CFG_ONE, cfg);
    @(posedge rmii_clk);
    t = $time;
    @(posedge rmii_clk);
    check("rmii_period", e, 33'($time - t));
  endtask
  task automatic txe(input logic en, input logic er, input logic e);
    mac.send(en, er, 1'b1);
    repeat (8) @(negedge ref_clk);
    check("tx_er", e, tx_er_out);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Read monitor takes the oldest expectation at each completed read
  always @(posedge ref_clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      if (exp_q.size() == 0) check("queue", 33'h0, 33'h1);
      else check("read", exp_q.pop_front(), {pslverr, prdata});
    end
  end
  // Watchdog for a hang; the whole run needs well under 20000 cycles
  initial begin
    #200000;
    fail_count++;
    stop_test();
  end
  initial begin
    {ref_clk, arst_n, psel, penable, pwrite, run, crs, dv} = '0;
    paddr = '0;
    pwdata = '0;
    seed = 32'hc563217f;
    strap = 5'($random(seed));
    repeat (20) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rd(IDX_CFG_ONE, 33'h4001);
    rd(IDX_CFG_TWO, 33'h3);
    rd(IDX_STRAP, {28'h0, strap});
    rd(8'hff, 33'h100000000);
    check("mii", 1'b1, mii);
    for (int i = 0; i < 4; i++) begin
      w = 16'($random(seed));
      w2 = 16'($random(seed));
      apb(1'b1, IDX_CFG_ONE, w);
      apb(1'b1, IDX_CFG_TWO, w2);
      rd(IDX_CFG_ONE, {17'h0, w & CFG_ONE_WMASK & 16'hfff3});
      rd(IDX_CFG_TWO, {17'h0, w2 & CFG_TWO_WMASK});
      check("rx_shift", w[12], rx_sh);
      check("tx_shift", w[11], tx_sh);
      check("rgmii", w[9], rg);
      check("rmii", !w[9] && w[5], rmii);
      check("mii", !w[9] && !w[5], mii);
      check("ref50", w[7], ref50);
    end
    apb(1'b1, IDX_CFG_TWO, 16'h0003);
    period(16'h0020, 33'd20);
    period(16'h0060, 33'd200);
    drain(16'h0021, 1'b0);
    drain(16'h0031, 1'b1);
    apb(1'b1, IDX_CFG_TWO, 16'h0403);
    frame(1'b1, 1'b0, 1'b1);
    frame(1'b0, 1'b1, 1'b0);
    frame(1'b0, 1'b0, 1'b0);
    rd(IDX_CFG_ONE, 33'h0039);
    rd(IDX_INT_STATUS, 33'h1);
    check("irq", 1'b0, irq);
    apb(1'b1, IDX_INT_MASK, 16'h0001);
    @(negedge ref_clk);
    check("irq", 1'b1, irq);
    apb(1'b1, IDX_INT_STATUS, 16'h0001);
    @(negedge ref_clk);
    check("irq", 1'b0, irq);
    apb(1'b1, IDX_CFG_ONE, 16'h0039);
    rd(IDX_CFG_ONE, 33'h0039);
    apb(1'b1, IDX_CFG_ONE, 16'h0031);
    rd(IDX_CFG_ONE, 33'h0031);
    apb(1'b1, IDX_CFG_ONE, 16'h0000);
    frame(1'b0, 1'b1, 1'b1);
    frame(1'b0, 1'b0, 1'b0);
    apb(1'b1, IDX_CFG_ONE, 16'h0200);
    apb(1'b1, IDX_CFG_TWO, 16'h0008);
    run <= 1'b1;
    txe(1'b0, 1'b1, 1'b0);
    txe(1'b1, 1'b1, 1'b1);
    apb(1'b1, IDX_CFG_TWO, 16'h0000);
    txe(1'b0, 1'b1, 1'b1);
    rd(IDX_CFG_TWO, 33'h0200);
    rd(IDX_INT_STATUS, 33'h4);
    run <= 1'b0;
    repeat (4) @(posedge ref_clk);
    stop_test();
  end
endmodule

//--- tb/mac_link_model.sv
// MAC partner: link clock and transmit pins.
// Assumes the bench raises run only while a frame is on the wire.
`timescale 1ns/1ps
module mac_link_model (
  input wire logic run, // Frame in progress
  output logic link_clk, // Link clock
  output logic tx_en, // Transmit enable
  output logic tx_er, // Transmit error
  output logic fd // Full duplex
);
  ////////////////////////////////////////////////////////////////////////
  // Clock stands still between frames so no stray edge reaches the trackers
  initial begin
    link_clk = 1'b0;
    forever #62.5 link_clk = run ? ~link_clk : 1'b0;
  end
  // Pins change by non-blocking assignment so the synchronisers never race them
  initial begin
    tx_en = 1'b0;
    tx_er = 1'b0;
    fd = 1'b0;
  end
  task automatic send(input logic en, input logic er, input logic d);
    tx_en <= en;
    tx_er <= er;
    fd <= d;
  endtask
endmodule
